/* File: rtl/pip_defs.vh */
// Register map, field layout and reset values of the peripheral interrupt enable/priority block
`ifndef PIP_DEFS_VH
`define PIP_DEFS_VH

// Register byte offsets
`define PIP_OFS_EN1 12'h000
`define PIP_OFS_EN2 12'h004
`define PIP_OFS_EN3 12'h008
`define PIP_OFS_PR1 12'h00C
`define PIP_OFS_PR2 12'h010
`define PIP_OFS_PR3 12'h014
`define PIP_OFS_CTRL 12'h018
`define PIP_OFS_STAT 12'h01C

// Implemented bits of each register group
`define PIP_MASK_1 8'h7F
`define PIP_MASK_2 8'h95
`define PIP_MASK_3 8'h1F

// Reset values
`define PIP_EN_RST 8'h00
`define PIP_CTRL_RST 8'h00

// Control register fields
`define PIP_CTRL_LEVELS 0
`define PIP_CTRL_GROUP 1
`define PIP_CTRL_QMODE_LO 4
`define PIP_CTRL_QMODE_HI 6
`define PIP_CTRL_MASK 8'h73

// Shared positions in the third group
`define PIP_BIT_CAP3_DIR 3
`define PIP_BIT_CAP2_ENC 2

// Status register fields
`define PIP_STAT_HIGH 24
`define PIP_STAT_LOW 25
`define PIP_STAT_QEI 26

`endif

/* File: rtl/pip_irq_ctrl.v */
// Peripheral interrupt enable and priority registers with high/low request routing
`timescale 1ns/1ps
`default_nettype none
`include "pip_defs.vh"

module pip_irq_ctrl #(
  parameter AW = 12
) (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [AW-1:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Peripheral flags, level, set by the peripherals
  input wire [7:0] periph_flags_1,
  input wire [7:0] periph_flags_2,
  input wire [7:0] periph_flags_3,
  input wire dir_change_flag,
  input wire encoder_flag,
  // Requests toward the core
  output reg irq_high,
  output reg irq_low
);

  // Register state
  reg [7:0] en1_ff;
  reg [7:0] en2_ff;
  reg [7:0] en3_ff;
  reg [7:0] pr1_ff;
  reg [7:0] pr2_ff;
  reg [7:0] pr3_ff;
  reg [7:0] ctrl_ff;
  reg [7:0] sel_flags_3;
  reg [7:0] req1;
  reg [7:0] req2;
  reg [7:0] req3;
  reg nxt_high;
  reg nxt_low;
  reg mapped;
  reg [31:0] rd_mux;
  wire qei_active;
  wire levels_en;
  wire group_en;
  wire access;
  wire wr_take;
  // Next values of the registers
  reg [7:0] nxt_en1;
  reg [7:0] nxt_en2;
  reg [7:0] nxt_en3;
  reg [7:0] nxt_pr1;
  reg [7:0] nxt_pr2;
  reg [7:0] nxt_pr3;
  reg [7:0] nxt_ctrl;
  reg nxt_pready;
  reg nxt_pslverr;
  reg [31:0] nxt_prdata;
  // Flat per-source vectors, group 1 in the low byte
  wire [23:0] flag_vec;
  wire [23:0] en_vec;
  wire [23:0] pr_vec;
  wire [23:0] impl_vec;
  wire [23:0] req_vec;
  wire [23:0] hi_vec;
  wire [23:0] lo_vec;
  genvar gi;

  assign qei_active = |ctrl_ff[`PIP_CTRL_QMODE_HI:`PIP_CTRL_QMODE_LO];
  assign levels_en = ctrl_ff[`PIP_CTRL_LEVELS];
  assign group_en = ctrl_ff[`PIP_CTRL_GROUP];
  // One wait state: access phase first sees pready low, then high
  assign access = psel & penable;
  assign wr_take = access & pready & pwrite;

  // Shared flag positions pick capture or encoder source
  always @* begin
    sel_flags_3 = periph_flags_3;
    sel_flags_3[`PIP_BIT_CAP3_DIR] = qei_active ? dir_change_flag : periph_flags_3[`PIP_BIT_CAP3_DIR];
    sel_flags_3[`PIP_BIT_CAP2_ENC] = qei_active ? encoder_flag : periph_flags_3[`PIP_BIT_CAP2_ENC];
  end

  // Flat source vectors; shared positions already steered above
  assign flag_vec = {sel_flags_3, periph_flags_2, periph_flags_1};
  assign en_vec = {en3_ff, en2_ff, en1_ff};
  assign pr_vec = {pr3_ff, pr2_ff, pr1_ff};
  assign impl_vec = {`PIP_MASK_3, `PIP_MASK_2, `PIP_MASK_1};

  // Per-source gating, one slice per flag bit
  generate
    for (gi = 0; gi < 24; gi = gi + 1) begin : g_src
      assign req_vec[gi] = flag_vec[gi] & en_vec[gi] & impl_vec[gi];
      assign hi_vec[gi] = req_vec[gi] & pr_vec[gi];
      assign lo_vec[gi] = req_vec[gi] & ~pr_vec[gi];
    end
  endgenerate

  // Request gating and level routing
  // Priority bits are kept even when unused, so software can set them first
  always @* begin
    req1 = req_vec[7:0];
    req2 = req_vec[15:8];
    req3 = req_vec[23:16];
    if (levels_en) begin
      nxt_high = |hi_vec;
      nxt_low = |lo_vec;
    end else begin
      nxt_high = group_en & (|req1 | |req2 | |req3);
      nxt_low = 1'b0;
    end
  end

  // Read decode; status shows live request state
  always @* begin
    mapped = 1'b1;
    rd_mux = 32'h0000_0000;
    case (paddr)
      `PIP_OFS_EN1: rd_mux[7:0] = en1_ff;
      `PIP_OFS_EN2: rd_mux[7:0] = en2_ff;
      `PIP_OFS_EN3: rd_mux[7:0] = en3_ff;
      `PIP_OFS_PR1: rd_mux[7:0] = pr1_ff;
      `PIP_OFS_PR2: rd_mux[7:0] = pr2_ff;
      `PIP_OFS_PR3: rd_mux[7:0] = pr3_ff;
      `PIP_OFS_CTRL: rd_mux[7:0] = ctrl_ff;
      `PIP_OFS_STAT: begin
        rd_mux[23:0] = {req3, req2, req1};
        rd_mux[`PIP_STAT_HIGH] = irq_high;
        rd_mux[`PIP_STAT_LOW] = irq_low;
        rd_mux[`PIP_STAT_QEI] = qei_active;
      end
      default: mapped = 1'b0;
    endcase
  end

  // APB next state; the answer always comes in the second access cycle
  always @* begin
    nxt_pready = access & ~pready;
    nxt_pslverr = access & ~pready & ~mapped;
    nxt_prdata = prdata;
    // Capture once, so data stands until the next read
    if (access && !pready && !pwrite) begin
      nxt_prdata = rd_mux;
    end
  end

  // APB handshake and read data registers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= nxt_pready;
      pslverr <= nxt_pslverr;
      prdata <= nxt_prdata;
    end
  end

  // Register writes take effect only at the edge where pready is high
  // Enable group 1 next value; only bits 6..0 can be set
  always @* begin
    nxt_en1 = en1_ff;
    if (wr_take && paddr == `PIP_OFS_EN1) begin
      nxt_en1 = pwdata[7:0] & `PIP_MASK_1;
    end
  end

  // Enable group 1 register
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en1_ff <= `PIP_EN_RST;
    end else begin
      en1_ff <= nxt_en1;
    end
  end

  // Enable group 2 next value; bits 7, 4, 2, 0 only
  always @* begin
    nxt_en2 = en2_ff;
    if (wr_take && paddr == `PIP_OFS_EN2) begin
      nxt_en2 = pwdata[7:0] & `PIP_MASK_2;
    end
  end

  // Enable group 2 register
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en2_ff <= `PIP_EN_RST;
    end else begin
      en2_ff <= nxt_en2;
    end
  end

  // Enable group 3 next value; bits 4..0 only
  always @* begin
    nxt_en3 = en3_ff;
    if (wr_take && paddr == `PIP_OFS_EN3) begin
      nxt_en3 = pwdata[7:0] & `PIP_MASK_3;
    end
  end

  // Enable group 3 register
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en3_ff <= `PIP_EN_RST;
    end else begin
      en3_ff <= nxt_en3;
    end
  end

  // Priority group 1 next value
  always @* begin
    nxt_pr1 = pr1_ff;
    if (wr_take && paddr == `PIP_OFS_PR1) begin
      nxt_pr1 = pwdata[7:0] & `PIP_MASK_1;
    end
  end

  // Priority group 1 register; all sources start at high level
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pr1_ff <= `PIP_MASK_1;
    end else begin
      pr1_ff <= nxt_pr1;
    end
  end

  // Priority group 2 next value
  always @* begin
    nxt_pr2 = pr2_ff;
    if (wr_take && paddr == `PIP_OFS_PR2) begin
      nxt_pr2 = pwdata[7:0] & `PIP_MASK_2;
    end
  end

  // Priority group 2 register
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pr2_ff <= `PIP_MASK_2;
    end else begin
      pr2_ff <= nxt_pr2;
    end
  end

  // Priority group 3 next value
  always @* begin
    nxt_pr3 = pr3_ff;
    if (wr_take && paddr == `PIP_OFS_PR3) begin
      nxt_pr3 = pwdata[7:0] & `PIP_MASK_3;
    end
  end

  // Priority group 3 register
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pr3_ff <= `PIP_MASK_3;
    end else begin
      pr3_ff <= nxt_pr3;
    end
  end

  // Control next value; status and unmapped writes leave it alone
  always @* begin
    nxt_ctrl = ctrl_ff;
    if (wr_take && paddr == `PIP_OFS_CTRL) begin
      nxt_ctrl = pwdata[7:0] & `PIP_CTRL_MASK;
    end
  end

  // Control register; levels and group enable start off
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= `PIP_CTRL_RST;
    end else begin
      ctrl_ff <= nxt_ctrl;
    end
  end

  // Registered request outputs, one cycle after flag or setting changes
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_high <= 1'b0;
      irq_low <= 1'b0;
    end else begin
      irq_high <= nxt_high;
      irq_low <= nxt_low;
    end
  end

endmodule // pip_irq_ctrl
`default_nettype wire

/* File: verif/pip_flag_src.sv */
// Peripheral flag source model
`timescale 1ns/1ps
`default_nettype none
module pip_flag_src (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Event strobes and clear
  input wire logic [25:0] ev,
  input wire logic clr,
  // Flag levels
  output logic [25:0] fl_ff
);
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) fl_ff <= '0;
    else fl_ff <= clr ? '0 : (fl_ff | ev);
  end
endmodule // pip_flag_src
`default_nettype wire

/* File: verif/pip_props.sv */
// Port checker for the enable and priority block
`timescale 1ns/1ps
`default_nettype none
`include "pip_defs.vh"
module pip_props #(parameter AW = 12) (
  // Bus side
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [AW-1:0] paddr,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // First access cycle, still waiting
  sequence s_wait;
    psel && penable && !pready;
  endsequence
  AST_ONE_WAIT: assert property (s_wait |=> pready) else $error("ready late");
  AST_PULSE: assert property (pready |=> !pready) else $error("ready too long");
  AST_ERR_RDY: assert property (pslverr |-> pready) else $error("stray error");
  AST_RDY_ACC: assert property (pready |-> psel && penable) else $error("ready outside access");
  AST_UNMAP: assert property (pslverr && !pwrite |-> prdata == 0) else $error("error read nonzero");
  AST_UPPER: assert property (pready && !pwrite && paddr != `PIP_OFS_STAT |-> prdata[31:8] == 0)
    else $error("upper bits set");
  AST_HOLD: assert property (!(psel && penable && !pwrite) |=> $stable(prdata)) else $error("read data moved");
  AST_MASK2: assert property (pready && !pwrite && paddr == `PIP_OFS_EN2 |-> (prdata[7:0] & ~`PIP_MASK_2) == 0)
    else $error("hole bit set");
endmodule // pip_props
bind pip_irq_ctrl pip_props #(.AW(AW)) pip_props_i (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr));
`default_nettype wire

/* File: verif/peripheral_irq_enable_priority_bench.sv */
// Bench for the enable and priority block
`timescale 1ns/1ps
`default_nettype none
`include "pip_defs.vh"
module peripheral_irq_enable_priority_bench;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, clr = 0, pready, pslverr, irq_high, irq_low, e;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, r;
  logic [25:0] ev = '0, fl;
  logic [7:0] rst [6] = '{8'h00, 8'h00, 8'h00, 8'h7F, 8'h95, 8'h1F};
  logic [7:0] msk [6] = '{8'h7F, 8'h95, 8'h1F, 8'h7F, 8'h95, 8'h1F};
  int n_mismatch = 0, cmp_count = 0, cyc = 0;
  pip_irq_ctrl pip_irq_ctrl_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .periph_flags_1(fl[7:0]),
    .periph_flags_2(fl[15:8]), .periph_flags_3(fl[23:16]), .dir_change_flag(fl[24]), .encoder_flag(fl[25]),
    .irq_high(irq_high), .irq_low(irq_low));
  pip_flag_src pip_flag_src_i (.pclk(pclk), .presetn(presetn), .ev(ev), .clr(clr), .fl_ff(fl));
  // Clock and hang guard
  initial forever #50 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      conclude();
    end
  end
  task chk(input logic [31:0] g, x);
    cmp_count++;
    if (g !== x) begin
      n_mismatch++;
      $display("Error t=%0t got %h exp %h", $time, g, x);
    end
  endtask
  // Bus cycle; waits for ready, never assumes latency
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // Values read here are those sampled at this edge; only the hang guard ends the wait
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task rd(input logic [11:0] a, input logic [31:0] x);
    apb(0, a, 0);
    chk(r, x);
  endtask
  task ci(input logic h, l);
    @(negedge pclk);
    chk({30'h0, irq_high, irq_low}, {30'h0, h, l});
    @(posedge pclk);
  endtask
  task pulse(input logic [25:0] v);
    ev <= v;
    @(posedge pclk);
    ev <= '0;
    @(posedge pclk);
  endtask
  // Reset values, then all-ones writes showing the holes
  task t_regs;
    for (int i = 0; i < 6; i++) begin
      rd(12'(4 * i), {24'h0, rst[i]});
    end
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, 12'(4 * i), 32'hFFFF_FFFF);
      rd(12'(4 * i), {24'h0, msk[i]});
    end
    apb(1'b1, 12'h020, 32'hFFFF_FFFF);
    chk({31'h0, e}, 32'h1);
    rd(12'h020, 32'h0);
    chk({31'h0, e}, 32'h1);
    $display("register test done");
  endtask
  // Level routing with and without priority levels
  task t_route;
    apb(1'b1, `PIP_OFS_CTRL, 32'h1);
    pulse(26'h1);
    ci(1'b1, 1'b0);
    apb(1'b1, `PIP_OFS_PR1, 32'h7E);
    ci(1'b0, 1'b1);
    apb(1'b1, `PIP_OFS_CTRL, 32'h0);
    ci(1'b0, 1'b0);
    apb(1'b1, `PIP_OFS_CTRL, 32'h2);
    ci(1'b1, 1'b0);
    apb(1'b1, `PIP_OFS_EN1, 32'h0);
    ci(1'b0, 1'b0);
    $display("routing test done");
  endtask
  // Shared positions in encoder mode and in capture mode
  task t_qei;
    clr <= 1'b1;
    @(posedge pclk);
    clr <= 1'b0;
    apb(1'b1, `PIP_OFS_CTRL, 32'h11);
    apb(1'b1, `PIP_OFS_PR3, 32'h17);
    pulse(26'h100_0000);
    ci(1'b0, 1'b1);
    rd(`PIP_OFS_STAT, 32'h0608_0000);
    pulse(26'h200_0000);
    ci(1'b1, 1'b1);
    apb(1'b1, `PIP_OFS_CTRL, 32'h1);
    ci(1'b0, 1'b0);
    pulse(26'h8_0000);
    ci(1'b0, 1'b1);
    $display("encoder test done");
  endtask
  task conclude;
    $display("mismatches %0d compares %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_route();
    t_qei();
    conclude();
  end
endmodule // peripheral_irq_enable_priority_bench
`default_nettype wire
